/* dv/fib_host.sv */
// Purpose: Host model issuing field writes, set loads and calibration starts
// Assumes: A request is taken at the rising edge that sees its strobe high
// Notes:   Strobe drops one edge later, so back to back calls never collide
`default_nettype none
module fib_host
  import fib_pkg::*;
(
  input  wire logic    ref_clk,
  output var logic     cmdWr,
  output var reg_sel_e cmdSel,
  output var logic [15:0] cmdData,
  output var logic     setLoad,
  output var logic [4:0]  setLoadIdx,
  output var logic [15:0] setLoadCold,
  output var logic [15:0] setLoadWarm,
  output var logic     autoCalStart
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels at time zero
  initial begin
    cmdWr = 1'b0;
    cmdSel = SEL_INTEG;
    cmdData = 16'h0000;
    setLoad = 1'b0;
    setLoadIdx = 5'h00;
    setLoadCold = 16'h0000;
    setLoadWarm = 16'h0000;
    autoCalStart = 1'b0;
  end
  // One field write; data inverted once released so stale values never match
  task automatic wr(input reg_sel_e s, input logic [15:0] d);
    @(posedge ref_clk);
    cmdWr <= 1'b1;
    cmdSel <= s;
    cmdData <= d;
    @(posedge ref_clk);
    cmdWr <= 1'b0;
    cmdData <= ~d;
  endtask
  // One stored set: both set values arrive together
  task automatic load(input logic [4:0] i, input logic [15:0] c, input logic [15:0] w);
    @(posedge ref_clk);
    setLoad <= 1'b1;
    setLoadIdx <= i;
    setLoadCold <= c;
    setLoadWarm <= w;
    @(posedge ref_clk);
    setLoad <= 1'b0;
    setLoadCold <= ~c;
    setLoadWarm <= ~w;
  endtask
  // Calibration start pulse
  task automatic autoCal();
    @(posedge ref_clk);
    autoCalStart <= 1'b1;
    @(posedge ref_clk);
    autoCalStart <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/frame_integrate_bg_correct_tb.sv */
// Purpose: Self-checking bench for the integrator and background stage
// Assumes: DEPTH shortened to 16 pixels per frame; outputs lag inputs two cycles
// Notes:   Expected beats are queued when driven and compared on the falling edge
`default_nettype none
module frame_integrate_bg_correct_tb
  import fib_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEP = 16;
  logic ref_clk, rst_n, autoEn;
  pix_s rawIn, tpcIn, rawOut, bgOut;
  corr_wr_s corrOut;
  logic [3:0] corrAddr;
  logic [4:0] activeSet, sIdx;
  logic [7:0] intCtrlRd, bgCtrlRd;
  logic [15:0] offsetRd, coldSetVal, warmSetVal, cData, sCold, sWarm;
  logic cWr, sLoad, acStart;
  reg_sel_e cSel;
  int img[DEP], acc[DEP];           // Reference image and running sums
  int qRaw[$], qBg[$], qCorr[$];    // Expected output beats, -1 is ignored
  int hOut, bgMode, bgBusy, off, nAcc, cpy, uCode, mean;
  int miscompares, numChecks;
  fib_host i_fib_host (.ref_clk(ref_clk), .cmdWr(cWr), .cmdSel(cSel), .cmdData(cData),
    .setLoad(sLoad), .setLoadIdx(sIdx), .setLoadCold(sCold), .setLoadWarm(sWarm),
    .autoCalStart(acStart));
  frame_integrate_bg_correct #(.DEPTH(DEP)) i_frame_integrate_bg_correct (
    .ref_clk(ref_clk), .rst_n(rst_n), .rawIn(rawIn), .tpcIn(tpcIn), .rawOut(rawOut),
    .bgOut(bgOut), .cmdWr(cWr), .cmdSel(cSel), .cmdData(cData), .setLoad(sLoad),
    .setLoadIdx(sIdx), .setLoadCold(sCold), .setLoadWarm(sWarm),
    .autoCalStart(acStart), .autoCalBgEnable(autoEn), .intCtrlRd(intCtrlRd),
    .bgCtrlRd(bgCtrlRd), .offsetRd(offsetRd), .activeSet(activeSet),
    .coldSetVal(coldSetVal), .warmSetVal(warmSetVal), .corrOut(corrOut),
    .corrAddr(corrAddr));
  // Clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic endOfTest();
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Full 32-bit compare; an empty queue gives -2, which no zero-extended beat can match
  task automatic chk(string n, int e, logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Pop one expectation; an output beat with nothing queued is a mismatch
  task automatic pop(string n, ref int q[$], input logic [20:0] g);
    int e;
    e = (q.size() > 0) ? q.pop_front() : -2;
    if (e != -1) chk(n, e, g);
  endtask
  function automatic int clampf(int v);
    return (v < 0) ? 0 : (v > 65535) ? 65535 : v;
  endfunction
  // Outputs are settled by the falling edge
  always @(negedge ref_clk) begin
    if (rawOut.valid) pop("rawOut", qRaw, {5'h00, rawOut.data});
    if (bgOut.valid) pop("bgOut", qBg, {5'h00, bgOut.data});
    if (corrOut.valid) pop("corrOut", qCorr, {corrAddr, corrOut.warm, corrOut.data});
  end
  task automatic settle(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Drive n whole frames on one stream and queue what must come out
  task automatic frame(bit raw, int n);
    logic [15:0] d;
    for (int f = 0; f < n; f++) for (int k = 0; k < DEP; k++) begin
      d = $urandom;
      @(posedge ref_clk);
      if (raw) begin
        rawIn <= '{1'b1, k == 0, d};
        qRaw.push_back(hOut ? img[k] : d);
      end else begin
        tpcIn <= '{1'b1, k == 0, d};
        qBg.push_back(bgBusy ? -1 : bgMode == 1 ? clampf(d - img[k] + off) :
                      bgMode == 2 ? img[k] : d);
      end
      if (f < nAcc) acc[k] += d;
      if (cpy != 0 && f == 0) qCorr.push_back((k << 17) | ((cpy - 1) << 16) | img[k]);
    end
    @(posedge ref_clk);
    rawIn.valid <= 1'b0;
    tpcIn.valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Start an integration, wait N+2 frames, then fold sums into the image
  task automatic integ(bit raw, int code);
    int sh;
    sh = (code == 1) ? 0 : code - 1;
    foreach (acc[k]) acc[k] = 0;
    nAcc = 1 << sh;
    if (raw) i_fib_host.wr(SEL_INTEG, 16'(code << 1));
    else i_fib_host.wr(SEL_BG, 16'(code << 1));
    settle(1);
    chk("busy", 1, raw ? intCtrlRd[7] : bgCtrlRd[7]);
    frame(raw, nAcc + 2);
    chk("done", 0, raw ? intCtrlRd[7] : bgCtrlRd[7]);
    foreach (img[k]) img[k] = acc[k] >> sh;
    nAcc = 0;
  endtask
  initial begin
    #100us;
    miscompares++;
    endOfTest();
  end
  initial begin
    rst_n = 1'b0;
    autoEn = 1'b0;
    rawIn = '0;
    tpcIn = '0;
    {hOut, bgMode, bgBusy, off, nAcc, cpy, uCode} = '0;
    void'($urandom(32'h96F1A855));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(1);
    chk("resetCtrl", 0, {intCtrlRd, bgCtrlRd});
    chk("resetOff", 0, offsetRd);
    frame(1, 1);
    frame(0, 1);
    integ(1, 1);
    for (int c = 4; c <= 7; c++) begin
      integ(1, c);
      i_fib_host.wr(SEL_INTEG, 16'((c << 1) | 1));
      hOut = 1;
      frame(1, 1);
      i_fib_host.wr(SEL_INTEG, 16'(c << 1));
      hOut = 0;
    end
    i_fib_host.load(5'h00, 16'h1110, 16'h2220);
    i_fib_host.load(5'h01, 16'h3330, 16'h4440);
    i_fib_host.wr(SEL_SET, 16'h0001);
    settle(2);
    chk("setVals", 32'h33304440, {coldSetVal, warmSetVal});
    i_fib_host.wr(SEL_SET, 16'h0002);
    settle(2);
    chk("activeSet", 1, activeSet);
    i_fib_host.wr(SEL_COLD, 16'hABC0);
    settle(2);
    chk("coldSet", 16'hABC0, coldSetVal);
    for (int t = 1; t <= 2; t++) begin
      i_fib_host.wr(SEL_INTEG, 16'((t << 4) | (7 << 1)));
      cpy = t;
      frame(1, 1);
      cpy = 0;
      frame(1, 1);
      i_fib_host.wr(SEL_INTEG, 16'(7 << 1));
      settle(2);
      chk("copySets", 32'hABC04440, {coldSetVal, warmSetVal});
    end
    integ(0, 5);
    uCode = 5;
    off = $urandom_range(16'hFFFF);
    i_fib_host.wr(SEL_OFFSET, 16'(off));
    settle(1);
    chk("offset", off, offsetRd);
    for (int m = 2; m >= 0; m--) begin
      i_fib_host.wr(SEL_BG, 16'(((m >> 1) << 4) | (uCode << 1) | (m & 1)));
      bgMode = m;
      frame(0, 1);
    end
    i_fib_host.autoCal();
    settle(1);
    chk("autoCalOff", 8'h0A, bgCtrlRd);
    autoEn <= 1'b1;
    i_fib_host.autoCal();
    settle(1);
    chk("autoCal", 8'h8F, bgCtrlRd);
    {bgBusy, bgMode, nAcc} = {32'd1, 32'd1, 32'd64};
    foreach (acc[k]) acc[k] = 0;
    frame(0, 66);
    foreach (img[k]) img[k] = acc[k] >> 6;
    {bgBusy, nAcc, mean} = '0;
    foreach (img[k]) mean += img[k];
    off = mean >> 4;
    settle(1);
    chk("mean", off, offsetRd);
    frame(0, 1);
    endOfTest();
  end
endmodule
`default_nettype wire

/* logic/fib_cfg.svh */
// Purpose: Offsets, field positions, reset values and codes of the integrator block
// Assumes: Command fields are eight or sixteen bits wide, as the serial commands set them
// Notes:   Included by bare name; definitions only
`ifndef FIB_CFG_SVH
`define FIB_CFG_SVH

// Integrator control field layout <d*cc bbba>
`define FIB_H_OUT_BIT      0
`define FIB_H_CODE_LSB     1
`define FIB_H_COPY_LSB     4
`define FIB_H_BUSY_BIT     7

// Background control field layout <c**a bbba>, output mode split over bits 4 and 0
`define FIB_U_MODE_LO_BIT  0
`define FIB_U_CODE_LSB     1
`define FIB_U_MODE_HI_BIT  4
`define FIB_U_BUSY_BIT     7

// Integration codes
`define FIB_CODE_NONE      3'h0
`define FIB_CODE_STORE     3'h1
`define FIB_CODE_AUTOCAL   3'h7

// Copy codes
`define FIB_COPY_COLD      2'h1
`define FIB_COPY_WARM      2'h2

// Background output modes
`define FIB_BG_PASS        2'h0
`define FIB_BG_SUBTRACT    2'h1
`define FIB_BG_IMAGE       2'h2

// Reset values
`define FIB_RST_CTRL       8'h00
`define FIB_RST_VALUE      16'h0000

`endif

/* logic/fib_pkg.sv */
// Purpose: Types shared by the frame integrator and background correction
// Assumes: Pixels are 16 bits wide
// Notes:   Constants live in fib_cfg.svh
`default_nettype none
package fib_pkg;
  // One pixel beat with its frame start mark
  typedef struct packed {
    logic        valid;
    logic        sof;
    logic [15:0] data;
  } pix_s;

  // One word written into the two-point correction store
  typedef struct packed {
    logic        valid;
    logic        warm;
    logic [15:0] data;
  } corr_wr_s;

  // Command field selected by a host write
  typedef enum logic [2:0] {
    SEL_INTEG  = 3'b000,
    SEL_COLD   = 3'b001,
    SEL_WARM   = 3'b010,
    SEL_OFFSET = 3'b011,
    SEL_BG     = 3'b100,
    SEL_SET    = 3'b101
  } reg_sel_e;

  // Integration and copy sequencers
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } seq_state_e;
endpackage
`default_nettype wire

/* logic/frame_integrate_bg_correct.sv */
// Purpose: Frame integrator / image store and background correction on one frame memory
// Assumes: Pixel streams synchronous to ref_clk, sof on the first pixel of a frame
// Notes:   Outputs lag inputs by two cycles; one stream at a time owns the memory
`default_nettype none
`include "fib_cfg.svh"

// Notes on behaviour
// - Integrator and background share one frame memory
// - Integrator on raw pixels, background after correction
// - Integrator output mode: pass or stored image
// - New integration code starts store or 8..64 average
// - Copy code 01 cold, 10 warm store
// - Copy leaves cold and warm set values alone
// - Read-only busy bit while integrating
// - Cold set value 16 bits, one per set
// - Warm set value 16 bits, loaded together
// - Offset added to each pixel in correction
// - Auto calibration sets offset to image mean
// - Background modes: pass, subtract plus offset, image
// - Background integration codes match integrator codes
// - Auto calibration may force background mode 01
// - Active set limited to loaded set count
module frame_integrate_bg_correct
  import fib_pkg::*;
#(
  parameter int DEPTH = 1024,  // Pixels per frame
  parameter int NSETS = 32     // Correction data sets
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire pix_s                     rawIn,
  input  wire pix_s                     tpcIn,
  output pix_s                          rawOut,
  output pix_s                          bgOut,
  input  wire logic                     cmdWr,
  input  wire reg_sel_e                 cmdSel,
  input  wire logic [15:0]              cmdData,
  input  wire logic                     setLoad,
  input  wire logic [$clog2(NSETS)-1:0] setLoadIdx,
  input  wire logic [15:0]              setLoadCold,
  input  wire logic [15:0]              setLoadWarm,
  input  wire logic                     autoCalStart,
  input  wire logic                     autoCalBgEnable,
  output logic [7:0]                    intCtrlRd,
  output logic [7:0]                    bgCtrlRd,
  output logic [15:0]                   offsetRd,
  output logic [$clog2(NSETS)-1:0]      activeSet,
  output logic [15:0]                   coldSetVal,
  output logic [15:0]                   warmSetVal,
  output corr_wr_s                      corrOut,
  output logic [$clog2(DEPTH)-1:0]      corrAddr
);
  localparam int AW   = $clog2(DEPTH);
  localparam int SW   = $clog2(NSETS);
  localparam int ACCW = 22;            // 64 x 16-bit sums fit in 22 bits
  localparam int MW   = 16 + AW;       // Sum of one whole finished frame

  initial begin
    if (DEPTH != (1 << AW) || DEPTH < 2) $error("DEPTH must be a power of two");
    if (NSETS < 2 || NSETS > 256) $error("NSETS out of range");
  end

  // Command fields
  logic [7:0]  hCtrl;                  // Integrator field, busy bit not stored
  logic [7:0]  uCtrl;                  // Background field, busy bit not stored
  logic [15:0] offset;                 // Background offset
  logic [15:0] coldSet [NSETS];        // Per set cold reference value
  logic [15:0] warmSet [NSETS];        // Per set warm reference value
  logic [SW:0] loadedCount;            // One above the highest set index loaded so far

  // Field decode
  wire        hOut     = hCtrl[`FIB_H_OUT_BIT];
  wire [2:0]  hCode    = hCtrl[`FIB_H_CODE_LSB +: 3];
  wire [1:0]  hCopy    = hCtrl[`FIB_H_COPY_LSB +: 2];
  wire [2:0]  uCode    = uCtrl[`FIB_U_CODE_LSB +: 3];
  wire [1:0]  bgMode   = {uCtrl[`FIB_U_MODE_HI_BIT], uCtrl[`FIB_U_MODE_LO_BIT]};
  wire [2:0]  newCode  = cmdData[`FIB_H_CODE_LSB +: 3];
  wire [1:0]  newCopy  = cmdData[`FIB_H_COPY_LSB +: 2];
  wire        codeOk   = newCode == `FIB_CODE_STORE || newCode[2];
  wire        wrH      = cmdWr && cmdSel == SEL_INTEG;
  wire        wrU      = cmdWr && cmdSel == SEL_BG;
  wire        autoBg   = autoCalStart && autoCalBgEnable;
  wire        startH   = wrH && newCode != hCode && codeOk;
  wire        startU   = (wrU && newCode != uCode && codeOk) || autoBg;
  wire        startCpy = wrH && newCopy != hCopy &&
                         (newCopy == `FIB_COPY_COLD || newCopy == `FIB_COPY_WARM);
  wire        setOk    = {1'b0, cmdData[SW-1:0]} < loadedCount && cmdData[15:SW] == '0;

  // Sequencer state
  seq_state_e intSt;                   // Integration sequencer
  seq_state_e cpySt;                   // Copy sequencer
  logic       ownerBg;                 // Background stage owns the running integration
  logic [2:0] intShift;                // log2 of frame count
  logic [5:0] frameCnt;                // Frames finished in this run
  logic       copyWarm;                // Copy target
  logic       meanPend;                // Offset follows the mean at the end
  logic       meanLoad;                // One cycle after the end, sum is complete
  logic [MW-1:0] meanSum;              // Sum of the finished image
  logic [AW-1:0] idxCnt;               // Pixel position in the owning stream

  wire busy     = intSt != ST_IDLE;
  wire busyH    = busy && !ownerBg;
  wire busyU    = busy && ownerBg;
  wire [2:0] startCode = startU ? (autoBg ? `FIB_CODE_AUTOCAL : newCode) : newCode;
  wire [2:0] startShift = startCode[2] ? ({1'b0, startCode[1:0]} + 3'h3) : 3'h0;
  wire [5:0] lastCnt  = 6'((7'h01 << intShift) - 7'h01);

  // Memory ownership: raw stream during an integrator run, or outside any run for a copy or image output, else corrected stream
  wire  engRaw = busy ? !ownerBg : (cpySt != ST_IDLE || hOut);
  pix_s eng;
  assign eng = engRaw ? rawIn : tpcIn;
  wire [AW-1:0] curIdx = eng.sof ? '0 : idxCnt;
  wire endRun   = eng.valid && eng.sof && intSt == ST_RUN && frameCnt == lastCnt;
  wire integ    = eng.valid && ((intSt == ST_WAIT && eng.sof) ||
                               (intSt == ST_RUN && !endRun));
  wire [5:0] fIdx = intSt == ST_WAIT ? 6'h00 : (eng.sof ? 6'(frameCnt + 6'h01) : frameCnt);
  wire cpyPix   = eng.valid && engRaw && ((cpySt == ST_WAIT && eng.sof) ||
                                          (cpySt == ST_RUN && !eng.sof));

  // Stage one registers
  pix_s          rawD, tpcD;
  logic          s1EngRaw, s1Integ, s1First, s1Last, s1Copy;
  logic [AW-1:0] s1Idx;
  logic [ACCW-1:0] rdData;

  // Accumulate and divide on the final frame
  // Stream choice follows the pixel in stage one, not the live owner, so a restart cannot
  // mix one stream's sums with the other's pixels
  wire [ACCW-1:0] sum    = (s1First ? '0 : rdData) + ACCW'(s1Integ ? (s1EngRaw ? rawD.data
                           : tpcD.data) : 16'h0000);
  wire [ACCW-1:0] wrData = s1Last ? (sum >> intShift) : sum;
  wire            memWr  = s1Integ;
  wire [15:0]     img    = rdData[15:0];

  frame_store #(.WIDTH(ACCW), .DEPTH(DEPTH)) u_store (
    .ref_clk (ref_clk),
    .rdAddr  (curIdx),
    .rdData  (rdData),
    .wrEn    (memWr),
    .wrAddr  (s1Idx),
    .wrData  (wrData)
  );

  // Background result: subtract image, add offset, clamp to 16 bits
  wire signed [17:0] bgSum = $signed({2'b00, tpcD.data}) - $signed({2'b00, img})
                           + $signed({2'b00, offset});
  wire [15:0] bgClamp = bgSum < 0 ? 16'h0000 : (bgSum > 18'sh0FFFF ? 16'hFFFF : bgSum[15:0]);
  wire bgUse = !s1EngRaw;

  // Command field writes; auto calibration wins over a host write to the same field
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hCtrl  <= `FIB_RST_CTRL;
      uCtrl  <= `FIB_RST_CTRL;
      offset <= `FIB_RST_VALUE;
    end else begin
      if (wrH) begin
        hCtrl <= {1'b0, cmdData[6:0]};
      end
      if (autoBg) begin
        uCtrl <= {uCtrl[7:5], 1'b0, `FIB_CODE_AUTOCAL, 1'b1};
      end else if (wrU) begin
        uCtrl <= {1'b0, cmdData[6:0]};
      end
      if (meanLoad && meanPend) begin
        offset <= meanSum[MW-1:AW];
      end else if (cmdWr && cmdSel == SEL_OFFSET) begin
        offset <= cmdData;
      end
    end
  end

  // Set values per data set; file load writes both together
  for (genvar s = 0; s < NSETS; s++) begin : g_set
    wire hit = cmdWr && activeSet == SW'(s);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        coldSet[s] <= `FIB_RST_VALUE;
        warmSet[s] <= `FIB_RST_VALUE;
      end else if (setLoad && setLoadIdx == SW'(s)) begin
        coldSet[s] <= setLoadCold;
        warmSet[s] <= setLoadWarm;
      end else begin
        if (hit && cmdSel == SEL_COLD) coldSet[s] <= cmdData;
        if (hit && cmdSel == SEL_WARM) warmSet[s] <= cmdData;
      end
    end
  end

  // Active set and loaded count; an out of range selection is ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeSet   <= '0;
      loadedCount <= '0;
      coldSetVal  <= `FIB_RST_VALUE;
      warmSetVal  <= `FIB_RST_VALUE;
    end else begin
      if (setLoad && {1'b0, setLoadIdx} >= loadedCount) begin
        loadedCount <= (SW + 1)'(setLoadIdx) + 1'b1;
      end
      if (cmdWr && cmdSel == SEL_SET && setOk) begin
        activeSet <= cmdData[SW-1:0];
      end
      coldSetVal <= coldSet[activeSet];
      warmSetVal <= warmSet[activeSet];
    end
  end

  // Integration sequencer: wait for frame start, count frames, stop at next start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intSt    <= ST_IDLE;
      ownerBg  <= 1'b0;
      intShift <= 3'h0;
      frameCnt <= 6'h00;
      meanPend <= 1'b0;
      meanLoad <= 1'b0;
    end else begin
      meanLoad <= endRun;
      if (startH || startU) begin
        // A restart abandons the running one; the host is expected to wait
        intSt    <= ST_WAIT;
        ownerBg  <= !startH;
        intShift <= startShift;
        frameCnt <= 6'h00;
        meanPend <= !startH && autoBg;
      end else begin
        case (intSt)
          ST_WAIT: if (eng.valid && eng.sof) intSt <= ST_RUN;
          ST_RUN: begin
            if (endRun) begin
              intSt <= ST_IDLE;
            end else if (eng.valid && eng.sof) begin
              frameCnt <= 6'(frameCnt + 6'h01);
            end
          end
          ST_IDLE: ;
          default: intSt <= ST_IDLE;
        endcase
        if (meanLoad) meanPend <= 1'b0;
      end
    end
  end

  // Copy sequencer: the stored image, over one whole raw frame, into the chosen reference store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpySt    <= ST_IDLE;
      copyWarm <= 1'b0;
    end else if (startCpy) begin
      cpySt    <= ST_WAIT;
      copyWarm <= newCopy == `FIB_COPY_WARM;
    end else begin
      case (cpySt)
        ST_WAIT: if (engRaw && rawIn.valid && rawIn.sof) cpySt <= ST_RUN;
        ST_RUN:  if (rawIn.valid && rawIn.sof) cpySt <= ST_IDLE;
        ST_IDLE: ;
        default: cpySt <= ST_IDLE;
      endcase
    end
  end

  // Stage one: delay both streams and capture what the memory read is for
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rawD     <= '0;
      tpcD     <= '0;
      s1EngRaw <= 1'b0;
      s1Integ  <= 1'b0;
      s1First  <= 1'b0;
      s1Last   <= 1'b0;
      s1Copy   <= 1'b0;
      s1Idx    <= '0;
      idxCnt   <= '0;
      meanSum  <= '0;
    end else begin
      rawD     <= rawIn;
      tpcD     <= tpcIn;
      s1EngRaw <= engRaw;
      s1Integ  <= integ;
      s1First  <= fIdx == 6'h00;
      s1Last   <= fIdx == lastCnt;
      s1Copy   <= cpyPix;
      s1Idx    <= curIdx;
      if (eng.valid) idxCnt <= AW'(curIdx + 1'b1);
      if (startU) begin
        meanSum <= '0;
      end else if (s1Integ && s1Last) begin
        meanSum <= MW'(meanSum + MW'(wrData[15:0]));
      end
    end
  end

  // Stage two: output pixels and copy words from flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rawOut   <= '0;
      bgOut    <= '0;
      corrOut  <= '0;
      corrAddr <= '0;
    end else begin
      rawOut <= rawD;
      if (hOut && s1EngRaw) rawOut.data <= img;
      bgOut <= tpcD;
      if (bgUse && bgMode == `FIB_BG_SUBTRACT) bgOut.data <= bgClamp;
      if (bgUse && bgMode == `FIB_BG_IMAGE) begin
        bgOut.data <= img;
      end
      corrOut  <= '{valid: s1Copy, warm: copyWarm, data: img};
      corrAddr <= s1Idx;
    end
  end

  // Read-back fields with live busy bits
  assign intCtrlRd = {busyH, hCtrl[6:0]};
  assign bgCtrlRd  = {busyU, uCtrl[6:0]};
  assign offsetRd  = offset;

  // Checks
  AST_RAW_PASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!hOut && rawIn.valid) ##1 !hOut |=> rawOut.data == $past(rawIn.data, 2))
    else $error("raw pass-through altered the pixel");
  AST_BUSY_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startH && !startU |=> intCtrlRd[`FIB_H_BUSY_BIT] && !bgCtrlRd[`FIB_U_BUSY_BIT])
    else $error("integrator busy not raised after start");
  AST_BG_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startU && !startH |=> bgCtrlRd[`FIB_U_BUSY_BIT])
    else $error("background busy not raised after start");
  AST_BUSY_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(busy) |-> $past(eng.valid && eng.sof) || $past(startCpy))
    else $error("integration ended away from a frame start");
  AST_SHARED_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    memWr |-> $past(intSt) != ST_IDLE)
    else $error("frame memory written with no integration running");
  AST_DIV: assert property (@(posedge ref_clk) disable iff (!rst_n)
    memWr && s1Last |-> wrData[ACCW-1:16] == '0)
    else $error("averaged pixel exceeds 16 bits");
  AST_COPY_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cpySt == ST_RUN && !cmdWr && !setLoad) ##1 (!cmdWr && !setLoad)
      |=> $stable(coldSetVal) && $stable(warmSetVal))
    else $error("copy disturbed a set value");
  AST_COPY_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    corrOut.valid |-> $past(cpySt, 2) != ST_IDLE)
    else $error("copy word outside a copy frame");
  AST_BG_PASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bgMode == `FIB_BG_PASS && tpcIn.valid) ##1 bgMode == `FIB_BG_PASS
      |=> bgOut.data == $past(tpcIn.data, 2))
    else $error("background pass mode altered the pixel");
  AST_AUTOCAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    autoBg |=> bgMode == `FIB_BG_SUBTRACT && uCode == `FIB_CODE_AUTOCAL)
    else $error("auto calibration did not enable background correction");
  AST_SET_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    activeSet == '0 || {1'b0, activeSet} < loadedCount)
    else $error("active set beyond loaded sets");

  COV_AVG64: cover property (@(posedge ref_clk) disable iff (!rst_n)
    endRun && intShift == 3'h6);
  COV_COPY: cover property (@(posedge ref_clk) disable iff (!rst_n)
    corrOut.valid && corrOut.warm);
  COV_MEAN: cover property (@(posedge ref_clk) disable iff (!rst_n) meanLoad && meanPend);
  COV_BGSUB: cover property (@(posedge ref_clk) disable iff (!rst_n)
    bgOut.valid && bgMode == `FIB_BG_SUBTRACT);
endmodule
`default_nettype wire

/* logic/frame_store.sv */
// Purpose: Frame memory shared by the integrator and the background stage
// Assumes: One read and one write port, read data one cycle after the address
// Notes:   No reset on the array; contents are undefined until first written
`default_nettype none
module frame_store #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 1024
) (
  input  wire logic                     ref_clk,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData
);
  logic [WIDTH-1:0] mem [DEPTH];  // Pixel sums or finished image

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("frame_store: bad size");
  end

  // Registered read, plain write
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire
